// ### rtl/mfd_pkg.sv
// package for the monitor mask-two and fan divisor register pair
// assumes a byte-wide register pointer port from the serial bus engine
package mfd_pkg;

  // register pointer addresses
  localparam logic [7:0] ADDR_STATUS_TWO = 8'h02;  // status two, read clears
  localparam logic [7:0] ADDR_MASK_TWO   = 8'h04;  // mask and mode two
  localparam logic [7:0] ADDR_FAN_DIV    = 8'h05;  // fan divisor and pin config

  // reset values
  localparam logic [7:0] MASK_TWO_RESET  = 8'h00;  // mask register power-on value
  localparam logic [3:0] FAN_DIV_UPPER   = 4'h5;   // fan divisor upper nibble at power-on
  localparam logic [7:0] STATUS_RESET    = 8'h00;  // status power-on value

  // mask and mode field positions
  localparam int MASK_TACH_TWO  = 3;  // masks tach two status
  localparam int MASK_INTRUSION = 4;  // masks intrusion status
  localparam int MASK_OVERTEMP  = 5;  // masks overtemp status
  localparam int MODE_HOT       = 6;  // hot temperature one-time mode
  localparam int MODE_OVERTEMP  = 7;  // overtemp one-time mode

  // status field positions
  localparam int STAT_HOT       = 0;  // hot temperature status
  localparam int STAT_TACH_TWO  = 3;  // tach two status
  localparam int STAT_INTRUSION = 4;  // intrusion status
  localparam int STAT_OVERTEMP  = 5;  // overtemp status

  // fan divisor field positions
  localparam int FAN_MODE_ONE   = 0;  // tach one level mode
  localparam int FAN_MODE_TWO   = 1;  // tach two level mode
  localparam int FAN_DIV_ONE_LO = 2;  // tach one divider low bit, also polarity
  localparam int FAN_DIV_TWO_LO = 4;  // tach two divider low bit
  localparam int FAN_PIN_OS     = 6;  // pin in overtemp mode
  localparam int FAN_PIN_RST    = 7;  // pin in reset mode

  // cycles after reset release before the id pins are captured
  localparam logic [1:0] VID_LOAD_CYCLE = 2'd2;

  // temperature comparator result for one limit pair
  typedef struct packed {
    logic above_high;  // reading above the high limit
    logic below_hyst;  // reading below the hysteresis limit
  } mfd_temp_cmp_t;

  // shared pin usage
  typedef enum logic [1:0] {
    MFD_PIN_OFF,
    MFD_PIN_OVERTEMP,
    MFD_PIN_RESET
  } mfd_pin_mode_t;

endpackage : mfd_pkg

// ### rtl/mfd_temp_event.sv
// one temperature event tracker: repeating or one-time status behaviour
// assumes compare results valid while conv_done_i pulses, same clock
`timescale 1ns/1ps
`default_nettype none
module mfd_temp_event (
  input  wire logic                   clock_i,     // system clock
  input  wire logic                   resetn_i,    // async reset, active low
  input  wire logic                   one_time_i,  // one-time mode select
  input  wire logic                   conv_done_i, // conversion finished pulse
  input  wire mfd_pkg::mfd_temp_cmp_t cmp_i,       // limit compare results
  input  wire logic                   clear_i,     // status read pulse
  output logic                        status_o     // sticky status bit
);
  import mfd_pkg::*;

  logic hot_state;  // above high and not yet back below hysteresis
  logic set_event;  // status is to be set this cycle

  // decide whether this conversion raises the status
  always_comb begin
    set_event = 1'b0;
    if (conv_done_i) begin
      if (one_time_i) begin
        // single event on each crossing in either direction
        set_event = (!hot_state && cmp_i.above_high) ||
                    (hot_state && cmp_i.below_hyst);
      end else begin
        // repeat on every conversion until below hysteresis
        set_event = cmp_i.above_high || (hot_state && !cmp_i.below_hyst);
      end
    end
  end

  // crossing state
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hot_state <= 1'b0;
    end else if (conv_done_i) begin
      if (cmp_i.above_high) begin
        hot_state <= 1'b1;
      end else if (cmp_i.below_hyst) begin
        hot_state <= 1'b0;
      end
    end
  end

  // sticky status, a set beats a read clear
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      status_o <= 1'b0;
    end else if (set_event) begin
      status_o <= 1'b1;
    end else if (clear_i) begin
      status_o <= 1'b0;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  sequence s_armed_high;
    one_time_i && hot_state && conv_done_i && cmp_i.above_high;
  endsequence

  // still hot and above high again: the status must not rise a second time
  property p_one_time_quiet;
    s_armed_high |=> !$rose(status_o);
  endproperty
  a_one_time_quiet: assert property (p_one_time_quiet)
    else $error("one-time mode raised status again while still hot");

  property p_repeat_raise;
    !one_time_i && conv_done_i && cmp_i.above_high |=> status_o;
  endproperty
  a_repeat_raise: assert property (p_repeat_raise)
    else $error("repeating mode missed a conversion above high limit");

  property p_fall_event;
    one_time_i && hot_state && conv_done_i && cmp_i.below_hyst
      && !cmp_i.above_high |=> status_o && !hot_state;
  endproperty
  a_fall_event: assert property (p_fall_event)
    else $error("one-time mode missed the drop below hysteresis");

endmodule : mfd_temp_event
`default_nettype wire

// ### rtl/mfd_regs.sv
// mask-two and fan divisor registers with their status and pin logic
// assumes the serial bus engine gives one-cycle register strobes on clock_i
`timescale 1ns/1ps
`default_nettype none
module mfd_regs (
  input  wire logic                   clock_i,             // 20 MHz system clock
  input  wire logic                   resetn_i,            // async power-on reset, low
  input  wire logic [7:0]             reg_addr_i,          // register pointer
  input  wire logic                   reg_wr_i,            // write strobe
  input  wire logic [7:0]             reg_wdata_i,         // write byte
  input  wire logic                   reg_rd_i,            // read strobe
  output logic      [7:0]             reg_rdata_o,         // read byte
  input  wire logic                   conv_done_i,         // conversion done pulse
  input  wire mfd_pkg::mfd_temp_cmp_t hot_cmp_i,           // hot limit compares
  input  wire mfd_pkg::mfd_temp_cmp_t overtemp_cmp_i,      // overtemp limit compares
  input  wire logic                   tach_two_count_i,    // tach two count limit hit
  input  wire logic                   tach_input_two_i,    // tach two pin level
  input  wire logic                   intrusion_flag_i,    // intrusion pin
  input  wire logic [3:0]             voltage_id_inputs_i, // id pins
  input  wire logic                   reset_request_i,     // reset pulse request
  output logic                        int_n_o,             // interrupt, active low
  output logic                        pin_out_o,           // shared pin drive level
  output logic                        pin_oe_o,            // shared pin drive enable
  output logic                        tach_one_level_o,    // tach one level mode
  output logic                        tach_two_level_o,    // tach two level mode
  output logic      [1:0]             tach_one_div_o,      // tach one divide log2
  output logic      [1:0]             tach_two_div_o       // tach two divide log2
);
  import mfd_pkg::*;

  logic [7:0]    mask_two;         // interrupt_mask_and_mode_two
  logic [7:0]    fan_div;          // fan_divisor_and_pin_config
  logic [7:0]    status_two;       // status two view
  logic [1:0]    vid_cnt;          // cycles since reset release
  logic          vid_done;         // id pins captured
  logic [3:0]    vid_s1;           // id pin sync stage one
  logic [3:0]    vid_s2;           // id pin sync stage two
  logic [2:0]    pin_s1;           // tach two, intrusion, reset request stage one
  logic [2:0]    pin_s2;           // same, stage two
  logic          tach_stat;        // tach two sticky status
  logic          intr_stat;        // intrusion sticky status
  logic          hot_stat;         // hot temperature status
  logic          os_stat;          // overtemp status
  logic          os_active;        // overtemp condition level
  logic          status_rd;        // read of status two
  logic          tach_event;       // tach two status set
  logic          tach_level_hit;   // tach two level condition
  mfd_pin_mode_t pin_mode;         // decoded pin usage

  assign status_rd  = reg_rd_i && (reg_addr_i == ADDR_STATUS_TWO);
  assign status_two = {2'b00, os_stat, intr_stat, tach_stat, 2'b00, hot_stat};

  // two-flop synchronisers for pins
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vid_s1 <= 4'h0;
      vid_s2 <= 4'h0;
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
    end else begin
      vid_s1 <= voltage_id_inputs_i;
      vid_s2 <= vid_s1;
      pin_s1 <= {reset_request_i, intrusion_flag_i, tach_input_two_i};
      pin_s2 <= pin_s1;
    end
  end

  // mask register, byte write
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mask_two <= MASK_TWO_RESET;
    end else if (reg_wr_i && reg_addr_i == ADDR_MASK_TWO) begin
      mask_two <= reg_wdata_i;
    end
  end

  // capture delay for id pins after reset release
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      vid_cnt  <= 2'd0;
      vid_done <= 1'b0;
    end else if (!vid_done) begin
      vid_cnt  <= vid_cnt + 2'd1;
      vid_done <= (vid_cnt == VID_LOAD_CYCLE);
    end
  end

  // fan divisor register; low nibble from id pins once settled
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fan_div <= {FAN_DIV_UPPER, 4'h0};
    end else if (reg_wr_i && reg_addr_i == ADDR_FAN_DIV) begin
      fan_div <= reg_wdata_i;
    end else if (!vid_done && vid_cnt == VID_LOAD_CYCLE) begin
      fan_div <= {FAN_DIV_UPPER, vid_s2};
    end
  end

  // read data register, unmapped reads give zero
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      if (reg_addr_i == ADDR_STATUS_TWO) begin
        reg_rdata_o <= status_two;
      end else if (reg_addr_i == ADDR_MASK_TWO) begin
        reg_rdata_o <= mask_two;
      end else if (reg_addr_i == ADDR_FAN_DIV) begin
        reg_rdata_o <= fan_div;
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

  // tach two: level mode with polarity, else count limit
  assign tach_level_hit = fan_div[FAN_DIV_ONE_LO] ? !pin_s2[0] : pin_s2[0];
  assign tach_event = fan_div[FAN_MODE_TWO] ? tach_level_hit : tach_two_count_i;

  // tach two and intrusion sticky status, set beats clear
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tach_stat <= STATUS_RESET[STAT_TACH_TWO];
      intr_stat <= STATUS_RESET[STAT_INTRUSION];
    end else begin
      tach_stat <= tach_event || (tach_stat && !status_rd);
      intr_stat <= pin_s2[1] || (intr_stat && !status_rd);
    end
  end

  // hot temperature tracker
  mfd_temp_event u_hot (
    .clock_i     (clock_i),
    .resetn_i    (resetn_i),
    .one_time_i  (mask_two[MODE_HOT]),
    .conv_done_i (conv_done_i),
    .cmp_i       (hot_cmp_i),
    .clear_i     (status_rd),
    .status_o    (hot_stat)
  );

  // overtemp tracker
  mfd_temp_event u_os (
    .clock_i     (clock_i),
    .resetn_i    (resetn_i),
    .one_time_i  (mask_two[MODE_OVERTEMP]),
    .conv_done_i (conv_done_i),
    .cmp_i       (overtemp_cmp_i),
    .clear_i     (status_rd),
    .status_o    (os_stat)
  );

  // overtemp level for the shared pin, held between crossings
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      os_active <= 1'b0;
    end else if (conv_done_i && overtemp_cmp_i.above_high) begin
      os_active <= 1'b1;
    end else if (conv_done_i && overtemp_cmp_i.below_hyst) begin
      os_active <= 1'b0;
    end
  end

  // interrupt from unmasked upper status
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      int_n_o <= 1'b1;
    end else begin
      int_n_o <= !((tach_stat && !mask_two[MASK_TACH_TWO]) ||
                   (intr_stat && !mask_two[MASK_INTRUSION]) ||
                   (os_stat && !mask_two[MASK_OVERTEMP]));
    end
  end

  // shared pin mode decode, reset mode first
  always_comb begin
    if (fan_div[FAN_PIN_RST]) begin
      pin_mode = MFD_PIN_RESET;
    end else if (fan_div[FAN_PIN_OS]) begin
      pin_mode = MFD_PIN_OVERTEMP;
    end else begin
      pin_mode = MFD_PIN_OFF;
    end
  end

  // open-drain drive of the shared pin
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_out_o <= 1'b0;
      pin_oe_o  <= 1'b0;
    end else begin
      pin_out_o <= 1'b0;
      case (pin_mode)
        MFD_PIN_RESET:    pin_oe_o <= pin_s2[2];
        MFD_PIN_OVERTEMP: pin_oe_o <= os_active;
        default:          pin_oe_o <= 1'b0;
      endcase
    end
  end

  // fan mode and divider outputs
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tach_one_level_o <= 1'b0;
      tach_two_level_o <= 1'b0;
      tach_one_div_o   <= 2'b00;
      tach_two_div_o   <= 2'b00;
    end else begin
      tach_one_level_o <= fan_div[FAN_MODE_ONE];
      tach_two_level_o <= fan_div[FAN_MODE_TWO];
      tach_one_div_o   <= fan_div[FAN_DIV_ONE_LO +: 2];
      tach_two_div_o   <= fan_div[FAN_DIV_TWO_LO +: 2];
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);

  property p_int_gate;
    1 |=> int_n_o == !$past((tach_stat && !mask_two[3]) || (intr_stat && !mask_two[4])
                            || (os_stat && !mask_two[5]));
  endproperty
  a_int_gate: assert property (p_int_gate)
    else $error("interrupt output does not match unmasked status");

  property p_vid_load;
    !vid_done && vid_cnt == 2'd2 && !reg_wr_i |=> fan_div == {4'h5, $past(vid_s2)};
  endproperty
  a_vid_load: assert property (p_vid_load)
    else $error("fan divisor not loaded from id pins at power-on");

  property p_pin_off;
    fan_div[7:6] == 2'b00 |=> !pin_oe_o;
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("shared pin driven while disabled");

  property p_pin_rst;
    fan_div[7] |=> pin_oe_o == $past(pin_s2[2]);
  endproperty
  a_pin_rst: assert property (p_pin_rst)
    else $error("reset mode pin does not follow reset request");

  property p_pin_os;
    fan_div[7:6] == 2'b01 |=> pin_oe_o == $past(os_active);
  endproperty
  a_pin_os: assert property (p_pin_os)
    else $error("overtemp mode pin does not follow overtemp level");

  property p_level_tach;
    fan_div[1] && (pin_s2[0] != fan_div[2]) |=> tach_stat;
  endproperty
  a_level_tach: assert property (p_level_tach)
    else $error("tach two level condition did not set status");

  sequence s_write_mask;
    reg_wr_i && reg_addr_i == 8'h04;
  endsequence

  property p_mask_hold;
    s_write_mask ##1 (!(reg_wr_i && reg_addr_i == 8'h04))[*2]
      |-> mask_two == $past(reg_wdata_i, 2);
  endproperty
  a_mask_hold: assert property (p_mask_hold)
    else $error("mask register lost its written value");

  property p_read_clear;
    status_rd && !pin_s2[1] |=> !intr_stat;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("status read did not clear intrusion bit");

endmodule : mfd_regs
`default_nettype wire

// ### tb/mfd_host_model.sv
// host-side register master model for the mask-two and fan divisor pair
// assumes the bench calls its tasks; drives on falling clock edges
`timescale 1ns/1ps
`default_nettype none
module mfd_host_model (
  input  wire logic       clock_i,  // system clock
  output logic      [7:0] addr_o,   // register pointer
  output logic            wr_o,     // write strobe
  output logic      [7:0] wdata_o,  // write byte
  output logic            rd_o,     // read strobe
  input  wire logic [7:0] rdata_i   // read byte
);
  // idle bus at time zero
  initial begin
    addr_o  = 8'h00;
    wr_o    = 1'b0;
    wdata_o = 8'h00;
    rd_o    = 1'b0;
  end

  // one byte per strobe, then pointer and data released to inverted values
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    addr_o  = a;
    wdata_o = d;
    wr_o    = 1'b1;
    @(negedge clock_i);
    wr_o    = 1'b0;
    addr_o  = ~a;
    wdata_o = ~d;
  endtask : write_reg

  // one byte per strobe, data taken once the strobe edge has registered it
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clock_i);
    addr_o = a;
    rd_o   = 1'b1;
    @(negedge clock_i);
    rd_o   = 1'b0;
    addr_o = ~a;
    d      = rdata_i;
  endtask : read_reg
endmodule : mfd_host_model
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the mask-two and fan divisor registers
// assumes the host model drives the register port on falling edges
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mfd_pkg::*;
  logic          clock_i, resetn_i;          // clock and power-on reset
  logic [7:0]    addr, wdata, rdata, v;      // register port, scratch
  logic          wr, rd, conv, tcount, tpin; // strobes, event inputs
  logic          intr, rreq, int_n, pout;    // pins
  logic          poe, l1, l2;                // pin enable, level modes
  logic [3:0]    voltage_id_inputs;                        // id pins
  logic          t;                          // tach two level hit seen so far
  logic [1:0]    d1, d2;                     // divider codes
  mfd_temp_cmp_t hot, ot;                    // compare results
  int            err_count, checks, cycles;  // counters
  logic [7:0]    e [12] = '{8'h21, 8'h01, 8'h01, 8'h20, 8'h00, 8'h21,
                            8'h20, 8'h20, 8'h20, 8'h01, 8'h00, 8'h21};
  logic [1:0]    c [6] = '{2'b10, 2'b10, 2'b00, 2'b01, 2'b01, 2'b10};

  mfd_regs dut_u (.clock_i(clock_i), .resetn_i(resetn_i), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .conv_done_i(conv), .hot_cmp_i(hot), .overtemp_cmp_i(ot),
    .tach_two_count_i(tcount), .tach_input_two_i(tpin), .intrusion_flag_i(intr),
    .voltage_id_inputs_i(voltage_id_inputs), .reset_request_i(rreq), .int_n_o(int_n),
    .pin_out_o(pout), .pin_oe_o(poe), .tach_one_level_o(l1),
    .tach_two_level_o(l2), .tach_one_div_o(d1), .tach_two_div_o(d2));

  mfd_host_model host_u (.clock_i(clock_i), .addr_o(addr), .wr_o(wr),
    .wdata_o(wdata), .rd_o(rd), .rdata_i(rdata));

  // 50 ns period clock
  always #25 clock_i = ~clock_i;

  // hang guard
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 8000) begin
      err_count++;
      end_of_test();
    end
  end

  // expected shared pin enable from mode bits, reset request, overtemp level
  function automatic logic pin_exp(logic [1:0] m, logic req, logic o);
    return m[1] ? req : (m[0] & o);
  endfunction : pin_exp

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
    logic [7:0] d;
    host_u.read_reg(a, d);
    check(d, x);
  endtask : rd_chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask : cyc

  // one conversion-done pulse with its compare results
  task automatic pulse(input mfd_temp_cmp_t h, input mfd_temp_cmp_t o);
    @(negedge clock_i);
    conv = 1'b1;
    hot  = h;
    ot   = o;
    @(negedge clock_i);
    conv = 1'b0;
  endtask : pulse

  // raise or drop the event behind status bit b
  task automatic src(input int b, input logic x);
    case (b)
      3: tcount = x;
      4: intr = x;
      default: pulse(2'b01, {x, ~x});
    endcase
  endtask : src

  task automatic end_of_test;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    void'($urandom(32'h30d876be));
    {clock_i, resetn_i, conv, tcount, tpin, intr, rreq} = '0;
    {err_count, checks, cycles} = '0;
    hot = 2'b01;
    ot  = 2'b01;
    voltage_id_inputs = 4'($urandom);
    repeat (16) @(posedge clock_i);
    @(negedge clock_i);
    resetn_i = 1'b1;
    cyc(6);
    // power-on values; id pins may pick active-low level mode for tach two
    t = voltage_id_inputs[1] & voltage_id_inputs[2];
    rd_chk(ADDR_MASK_TWO, MASK_TWO_RESET);
    rd_chk(ADDR_FAN_DIV, {FAN_DIV_UPPER, voltage_id_inputs});
    rd_chk(ADDR_STATUS_TWO, {STATUS_RESET[7:4], t, STATUS_RESET[2:0]});
    check({6'h00, int_n, poe}, {6'h00, ~t, 1'b0});
    $display("test reset done");
    // field decode, every divider code then random bytes
    for (int i = 0; i < 8; i++) begin
      v = (i < 4) ? {2'($urandom), i[1:0], ~i[1:0], 2'($urandom)} : 8'($urandom);
      t = t | (v[1] & v[2]);
      host_u.write_reg(ADDR_FAN_DIV, v);
      host_u.write_reg(ADDR_MASK_TWO, ~v);
      rd_chk(ADDR_FAN_DIV, v);
      rd_chk(ADDR_MASK_TWO, ~v);
      check({6'h00, l2, l1}, {6'h00, v[1:0]});
      check({6'h00, d1}, {6'h00, v[3:2]});
      check({6'h00, d2}, {6'h00, v[5:4]});
    end
    host_u.write_reg(8'h07, 8'hA5);
    rd_chk(8'h07, 8'h00);
    rd_chk(ADDR_FAN_DIV, v);
    host_u.write_reg(ADDR_FAN_DIV, 8'h00);
    host_u.write_reg(ADDR_MASK_TWO, 8'h00);
    cyc(4);
    rd_chk(ADDR_STATUS_TWO, {4'h0, t, 3'h0});
    host_u.write_reg(ADDR_STATUS_TWO, 8'hFF);
    rd_chk(ADDR_STATUS_TWO, 8'h00);
    $display("test fields done");
    // masking of bits 3 to 5
    for (int b = 3; b < 6; b++) begin
      host_u.write_reg(ADDR_MASK_TWO, 8'(8'h01 << b));
      src(b, 1'b1);
      cyc(6);
      check({7'h00, int_n}, 8'h01);
      host_u.write_reg(ADDR_MASK_TWO, 8'h00);
      cyc(2);
      check({7'h00, int_n}, 8'h00);
      src(b, 1'b0);
      cyc(6);
      rd_chk(ADDR_STATUS_TWO, 8'(8'h01 << b));
      rd_chk(ADDR_STATUS_TWO, 8'h00);
      cyc(2);
      check({7'h00, int_n}, 8'h01);
    end
    $display("test mask done");
    // overtemp one-time with hot repeating, then hot one-time with overtemp repeating
    for (int i = 0; i < 12; i++) begin
      if (i % 6 == 0) begin
        host_u.write_reg(ADDR_MASK_TWO, (i < 6) ? 8'h80 : 8'h40);
      end
      pulse(c[i % 6], c[i % 6]);
      cyc(1);
      check({7'h00, int_n}, {7'h00, ~e[i][5]});
      rd_chk(ADDR_STATUS_TWO, e[i]);
      rd_chk(ADDR_STATUS_TWO, 8'h00);
    end
    $display("test modes done");
    // tach two level polarity
    for (int p = 0; p < 2; p++) begin
      host_u.write_reg(ADDR_FAN_DIV, p ? 8'h06 : 8'h02);
      cyc(2);
      tpin = ~p[0];
      cyc(6);
      tpin = p[0];
      cyc(6);
      rd_chk(ADDR_STATUS_TWO, 8'h08);
      rd_chk(ADDR_STATUS_TWO, 8'h00);
    end
    $display("test polarity done");
    // shared pin in each of the four mode codes
    for (int m = 0; m < 4; m++) begin
      host_u.write_reg(ADDR_FAN_DIV, {m[1:0], 6'h00});
      rreq = 1'b1;
      pulse(2'b01, 2'b10);
      cyc(5);
      check({6'h00, pout, poe}, {7'h00, pin_exp(m[1:0], 1'b1, 1'b1)});
      rreq = 1'b0;
      cyc(5);
      check({6'h00, pout, poe}, {7'h00, pin_exp(m[1:0], 1'b0, 1'b1)});
      rreq = 1'b1;
      pulse(2'b01, 2'b01);
      cyc(5);
      check({6'h00, pout, poe}, {7'h00, pin_exp(m[1:0], 1'b1, 1'b0)});
    end
    $display("test pin done");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
